// ==== hw/pcm_pkg.sv ====
// constants, register map and timing for the power-sourcing config and monitor register bank
// Behaviour
// - two-event class code 00 off, 01/11 on
// - non-zero deferral N runs N times 10 ms period
// - timer zero forwards pending events, reloads
// - deferral field reads last written value
// - deferral zero passes events immediately
// - powered current below threshold runs disconnect timer
// - per-port two-bit disconnect code selects milliamps
// - three-bit cut fields, two ports per register
// - above cut threshold runs fault timer, shuts port
// - cut codes map to fixed nominal milliamps
// - die temperature eight-bit read-only code
// - input voltage fourteen-bit read-only code
// - input voltage refreshed about once per second
// - port 1 current at 30h and 31h
// - current step set by sense resistor
// - semi-auto arms by class enable or pushbutton
package pcm_pkg;

	// clock and timing
	localparam int CLK_HZ           = 50_000_000;
	localparam int CLK_KHZ          = CLK_HZ / 1000;
	localparam int DEFER_STEP_MS    = 10;
	localparam int DEFER_STEP_CYC   = DEFER_STEP_MS * CLK_KHZ;
	localparam int VIN_REFRESH_MS   = 1000;
	localparam int VIN_REFRESH_CYC  = VIN_REFRESH_MS * CLK_KHZ;
	localparam int DIS_TIME_MS      = 300;
	localparam int DIS_TIME_CYC     = DIS_TIME_MS * CLK_KHZ;
	localparam int CUT_TIME_MS      = 60;
	localparam int CUT_TIME_CYC     = CUT_TIME_MS * CLK_KHZ;
	localparam int CNT_W            = 26;

	// register map, command byte offsets
	localparam logic [7:0] ADDR_TWO_EVENT_CLASS = 8'h21;
	localparam logic [7:0] ADDR_INT_DEFERRAL    = 8'h27;
	localparam logic [7:0] ADDR_DISC_THRESHOLD  = 8'h29;
	localparam logic [7:0] ADDR_CUT_PORTS_1_2   = 8'h2A;
	localparam logic [7:0] ADDR_CUT_PORTS_3_4   = 8'h2B;
	localparam logic [7:0] ADDR_DIE_TEMP        = 8'h2C;
	localparam logic [7:0] ADDR_VIN_LO          = 8'h2E;
	localparam logic [7:0] ADDR_VIN_HI          = 8'h2F;
	localparam logic [7:0] ADDR_CUR1_LO         = 8'h30;
	localparam logic [7:0] ADDR_CUR1_HI         = 8'h31;
	localparam logic [7:0] REG_RESET            = 8'h00;
	localparam logic [7:0] CUT_FIELD_MASK       = 8'h77;
	localparam logic [7:0] UNMAPPED_READ        = 8'h00;

	// field layout
	localparam int DEFER_LSB  = 0;
	localparam int DEFER_W    = 4;
	localparam int CLASS_W    = 2;
	localparam int DISC_W     = 2;
	localparam int CUT_W      = 3;
	localparam int CUT_NIBBLE = 4;
	localparam int MEAS_W     = 14;
	localparam int TEMP_W     = 8;
	localparam int PORTS      = 4;
	localparam int BYTE_BITS  = 8;

	// thresholds, current step in nA for a 255 mOhm sense resistor, 250 mOhm gives 62260
	localparam int I_STEP_255_NA = 61039;
	localparam int I_STEP_250_NA = 62260;
	localparam int DISC_UA [0:3] = '{7500, 15000, 30000, 50000};
	localparam int CUT_MA  [0:7] = '{374, 110, 204, 374, 754, 592, 645, 920};

	// result scaling, for software: temperature -20 C + N * 0.7 C, voltage N * 3.662 mV
	localparam int TEMP_OFFSET_C   = -20;
	localparam int TEMP_STEP_MC    = 700;
	localparam int VIN_STEP_UV     = 3662;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_AACK = 9'h004,
		ST_CMD  = 9'h008,
		ST_CACK = 9'h010,
		ST_WR   = 9'h020,
		ST_WACK = 9'h040,
		ST_RD   = 9'h080,
		ST_RACK = 9'h100
	} pcm_i2c_state_t;

endpackage

// ==== hw/pcm_port_timer.sv ====
// per-port disconnect and overcurrent-cut timers
`timescale 1ns/1ns
module pcm_port_timer #(
	parameter logic [pcm_pkg::CNT_W-1:0] DIS_CYCLES = pcm_pkg::CNT_W'(pcm_pkg::DIS_TIME_CYC),
	parameter logic [pcm_pkg::CNT_W-1:0] CUT_CYCLES = pcm_pkg::CNT_W'(pcm_pkg::CUT_TIME_CYC),
	parameter int                        I_STEP_NA  = pcm_pkg::I_STEP_255_NA
) (
	// clock and reset
	input  wire logic                           ref_clk_i,
	input  wire logic                           sys_rst_i,
	// port state
	input  wire logic                           powered_i,
	input  wire logic [pcm_pkg::MEAS_W-1:0]     current_i,
	input  wire logic [pcm_pkg::DISC_W-1:0]     disc_code_i,
	input  wire logic [pcm_pkg::CUT_W-1:0]      cut_code_i,
	// shutdown pulses
	output logic                                disconnect_o,
	output logic                                cut_fault_o
);

	logic [pcm_pkg::MEAS_W-1:0] dis_tab [0:3];
	logic [pcm_pkg::MEAS_W-1:0] cut_tab [0:7];
	logic [pcm_pkg::CNT_W-1:0]  dis_cnt_r;
	logic [pcm_pkg::CNT_W-1:0]  cut_cnt_r;
	logic                       dis_done_r;
	logic                       cut_done_r;
	logic                       below_w;
	logic                       over_w;

	// thresholds become current codes at elaboration, so no runtime divider
	for (genvar g = 0; g < 4; g++) begin : g_dis
		assign dis_tab[g] = pcm_pkg::MEAS_W'(pcm_pkg::DISC_UA[g] * 1000 / I_STEP_NA);
	end
	for (genvar g = 0; g < 8; g++) begin : g_cut
		assign cut_tab[g] = pcm_pkg::MEAS_W'(pcm_pkg::CUT_MA[g] * 1_000_000 / I_STEP_NA);
	end

	assign below_w = powered_i & (current_i < dis_tab[disc_code_i]);
	assign over_w  = powered_i & (current_i > cut_tab[cut_code_i]);

	// each timer restarts when its condition drops and fires once per episode
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dis_cnt_r    <= '0;
			dis_done_r   <= 1'b0;
			disconnect_o <= 1'b0;
		end else begin
			disconnect_o <= below_w & ~dis_done_r & (dis_cnt_r == '0);
			if (!below_w) begin
				dis_cnt_r  <= DIS_CYCLES - 1'b1;
				dis_done_r <= 1'b0;
			end else if (dis_cnt_r == '0) begin
				dis_done_r <= 1'b1;
			end else begin
				dis_cnt_r <= dis_cnt_r - 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cut_cnt_r   <= '0;
			cut_done_r  <= 1'b0;
			cut_fault_o <= 1'b0;
		end else begin
			cut_fault_o <= over_w & ~cut_done_r & (cut_cnt_r == '0);
			if (!over_w) begin
				cut_cnt_r  <= CUT_CYCLES - 1'b1;
				cut_done_r <= 1'b0;
			end else if (cut_cnt_r == '0) begin
				cut_done_r <= 1'b1;
			end else begin
				cut_cnt_r <= cut_cnt_r - 1'b1;
			end
		end
	end

endmodule

// ==== hw/pcm_regs.sv ====
// i2c register bank: classification, interrupt deferral, thresholds and measurement results
`timescale 1ns/1ns
module pcm_regs #(
	parameter logic [6:0]                DEV_ADDR    = 7'h20,
	parameter int                        IRQ_W       = 8,
	parameter logic [pcm_pkg::CNT_W-1:0] STEP_CYC    = pcm_pkg::CNT_W'(pcm_pkg::DEFER_STEP_CYC),
	parameter logic [pcm_pkg::CNT_W-1:0] REFRESH_CYC = pcm_pkg::CNT_W'(pcm_pkg::VIN_REFRESH_CYC),
	parameter logic [pcm_pkg::CNT_W-1:0] DIS_CYCLES  = pcm_pkg::CNT_W'(pcm_pkg::DIS_TIME_CYC),
	parameter logic [pcm_pkg::CNT_W-1:0] CUT_CYCLES  = pcm_pkg::CNT_W'(pcm_pkg::CUT_TIME_CYC),
	parameter int                        I_STEP_NA   = pcm_pkg::I_STEP_255_NA
) (
	// clock and reset
	input  wire logic                                          ref_clk_i,
	input  wire logic                                          sys_rst_i,
	// i2c pins, sda open drain
	input  wire logic                                          scl_i,
	input  wire logic                                          sda_i,
	output logic                                               sda_o,
	output logic                                               sda_oe_o,
	// non-critical interrupt events
	input  wire logic [IRQ_W-1:0]                              noncrit_event_i,
	output logic      [IRQ_W-1:0]                              irq_event_o,
	// measurement results from the converter
	input  wire logic                                          meas_valid_i,
	input  wire logic [pcm_pkg::TEMP_W-1:0]                    temp_code_i,
	input  wire logic [pcm_pkg::MEAS_W-1:0]                    vin_code_i,
	input  wire logic [pcm_pkg::PORTS-1:0][pcm_pkg::MEAS_W-1:0] port_current_i,
	// port control
	input  wire logic [pcm_pkg::PORTS-1:0]                     port_powered_i,
	output logic      [pcm_pkg::PORTS-1:0]                     disconnect_o,
	output logic      [pcm_pkg::PORTS-1:0]                     overcurrent_fault_o,
	// two-event classification
	input  wire logic                                          semi_auto_mode_i,
	input  wire logic [pcm_pkg::PORTS-1:0]                     classification_enable_i,
	input  wire logic [pcm_pkg::PORTS-1:0]                     power_on_pushbutton_i,
	input  wire logic [pcm_pkg::PORTS-1:0]                     class4_result_i,
	output logic      [pcm_pkg::PORTS-1:0]                     second_class_event_enable_o,
	output logic      [pcm_pkg::PORTS-1:0]                     second_class_start_o
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and bus conditions

	logic scl_s1_r;
	logic scl_s2_r;
	logic scl_d_r;
	logic sda_s1_r;
	logic sda_s2_r;
	logic sda_d_r;

	// bus idles high, so the synchronisers reset high to avoid a false start
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r  <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r  <= 1'b1;
		end else begin
			scl_s1_r <= scl_i;
			scl_s2_r <= scl_s1_r;
			scl_d_r  <= scl_s2_r;
			sda_s1_r <= sda_i;
			sda_s2_r <= sda_s1_r;
			sda_d_r  <= sda_s2_r;
		end
	end

	logic scl_rise_w;
	logic scl_fall_w;
	logic start_w;
	logic stop_w;

	assign scl_rise_w = scl_s2_r & ~scl_d_r;
	assign scl_fall_w = ~scl_s2_r & scl_d_r;
	assign start_w    = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	assign stop_w     = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

	////////////////////////////////////////////////////////////////////////////////
	// i2c slave: address, command byte, then auto-incrementing data bytes

	pcm_pkg::pcm_i2c_state_t state_r;
	logic [3:0]              bits_r;
	logic [7:0]              shift_r;
	logic [7:0]              ptr_r;
	logic                    rw_r;
	logic                    ack_r;
	logic                    sda_oe_r;
	logic [7:0]              rd_byte_w;
	logic                    byte_done_w;
	logic                    rd_load_w;
	logic                    wr_stb_w;

	assign byte_done_w = scl_fall_w & (bits_r == 4'(pcm_pkg::BYTE_BITS));
	assign rd_load_w   = scl_fall_w & (((state_r == pcm_pkg::ST_AACK) & rw_r) | ((state_r == pcm_pkg::ST_RACK) & ack_r));
	assign wr_stb_w    = (state_r == pcm_pkg::ST_WR) & byte_done_w;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r  <= pcm_pkg::ST_IDLE;
			bits_r   <= '0;
			shift_r  <= '0;
			ptr_r    <= '0;
			rw_r     <= 1'b0;
			ack_r    <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (start_w) begin
			state_r  <= pcm_pkg::ST_ADDR;
			bits_r   <= '0;
			sda_oe_r <= 1'b0;
		end else if (stop_w) begin
			state_r  <= pcm_pkg::ST_IDLE;
			sda_oe_r <= 1'b0;
		end else if (rd_load_w) begin
			state_r  <= pcm_pkg::ST_RD;
			shift_r  <= rd_byte_w;
			sda_oe_r <= ~rd_byte_w[7];
			bits_r   <= 4'h1;
			ptr_r    <= ptr_r + 8'h01;
		end else begin
			unique case (state_r)
				pcm_pkg::ST_IDLE: begin
				end
				pcm_pkg::ST_ADDR, pcm_pkg::ST_CMD, pcm_pkg::ST_WR: begin
					if (scl_rise_w) begin
						shift_r <= {shift_r[6:0], sda_s2_r};
						bits_r  <= bits_r + 4'h1;
					end else if (byte_done_w) begin
						bits_r   <= '0;
						sda_oe_r <= 1'b1;
						if (state_r == pcm_pkg::ST_ADDR) begin
							rw_r     <= shift_r[0];
							sda_oe_r <= (shift_r[7:1] == DEV_ADDR);
							state_r  <= (shift_r[7:1] == DEV_ADDR) ? pcm_pkg::ST_AACK : pcm_pkg::ST_IDLE;
						end else if (state_r == pcm_pkg::ST_CMD) begin
							ptr_r   <= shift_r;
							state_r <= pcm_pkg::ST_CACK;
						end else begin
							ptr_r   <= ptr_r + 8'h01;
							state_r <= pcm_pkg::ST_WACK;
						end
					end
				end
				pcm_pkg::ST_AACK, pcm_pkg::ST_CACK, pcm_pkg::ST_WACK: begin
					if (scl_fall_w) begin
						sda_oe_r <= 1'b0;
						state_r  <= (state_r == pcm_pkg::ST_AACK) ? pcm_pkg::ST_CMD : pcm_pkg::ST_WR;
					end
				end
				pcm_pkg::ST_RD: begin
					if (byte_done_w) begin
						sda_oe_r <= 1'b0;
						state_r  <= pcm_pkg::ST_RACK;
					end else if (scl_fall_w) begin
						sda_oe_r <= ~shift_r[6];
						shift_r  <= {shift_r[6:0], 1'b0};
						bits_r   <= bits_r + 4'h1;
					end
				end
				pcm_pkg::ST_RACK: begin
					if (scl_rise_w) begin
						ack_r <= ~sda_s2_r;
					end else if (scl_fall_w) begin
						state_r <= pcm_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	assign sda_o    = 1'b0;
	assign sda_oe_o = sda_oe_r;

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [7:0] class_r;
	logic [7:0] defer_r;
	logic [7:0] disc_r;
	logic [7:0] cut12_r;
	logic [7:0] cut34_r;

	logic wr_class_w;
	logic wr_defer_w;
	logic wr_disc_w;
	logic wr_cut12_w;
	logic wr_cut34_w;

	assign wr_class_w = wr_stb_w & (ptr_r == pcm_pkg::ADDR_TWO_EVENT_CLASS);
	assign wr_defer_w = wr_stb_w & (ptr_r == pcm_pkg::ADDR_INT_DEFERRAL);
	assign wr_disc_w  = wr_stb_w & (ptr_r == pcm_pkg::ADDR_DISC_THRESHOLD);
	assign wr_cut12_w = wr_stb_w & (ptr_r == pcm_pkg::ADDR_CUT_PORTS_1_2);
	assign wr_cut34_w = wr_stb_w & (ptr_r == pcm_pkg::ADDR_CUT_PORTS_3_4);

	// writes anywhere else, the result registers included, fall through unused
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			class_r <= pcm_pkg::REG_RESET;
			defer_r <= pcm_pkg::REG_RESET;
			disc_r  <= pcm_pkg::REG_RESET;
			cut12_r <= pcm_pkg::REG_RESET;
			cut34_r <= pcm_pkg::REG_RESET;
		end else begin
			if (wr_class_w) class_r <= shift_r;
			// reserved high bits are stored and read back but steer nothing
			if (wr_defer_w) defer_r <= shift_r;
			if (wr_disc_w)  disc_r  <= shift_r;
			if (wr_cut12_w) cut12_r <= shift_r & pcm_pkg::CUT_FIELD_MASK;
			if (wr_cut34_w) cut34_r <= shift_r & pcm_pkg::CUT_FIELD_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// measurement results

	logic [pcm_pkg::TEMP_W-1:0] temp_r;
	logic [pcm_pkg::MEAS_W-1:0] vin_r;
	logic [pcm_pkg::MEAS_W-1:0] cur1_r;
	logic [pcm_pkg::CNT_W-1:0]  refresh_cnt_r;
	logic [5:0]                 hi_hold_r;
	logic                       refresh_w;

	assign refresh_w = (refresh_cnt_r == REFRESH_CYC - 1'b1);

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			temp_r        <= '0;
			vin_r         <= '0;
			cur1_r        <= '0;
			refresh_cnt_r <= '0;
		end else begin
			refresh_cnt_r <= refresh_w ? '0 : refresh_cnt_r + 1'b1;
			if (refresh_w) vin_r <= vin_code_i;
			if (meas_valid_i) begin
				temp_r <= temp_code_i;
				cur1_r <= port_current_i[0];
			end
		end
	end

	// high byte is frozen when the low byte goes out so a pair never tears
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hi_hold_r <= '0;
		end else if (rd_load_w && ptr_r == pcm_pkg::ADDR_VIN_LO) begin
			hi_hold_r <= vin_r[13:8];
		end else if (rd_load_w && ptr_r == pcm_pkg::ADDR_CUR1_LO) begin
			hi_hold_r <= cur1_r[13:8];
		end
	end

	assign rd_byte_w =
		(ptr_r == pcm_pkg::ADDR_TWO_EVENT_CLASS) ? class_r :
		(ptr_r == pcm_pkg::ADDR_INT_DEFERRAL)    ? defer_r :
		(ptr_r == pcm_pkg::ADDR_DISC_THRESHOLD)  ? disc_r :
		(ptr_r == pcm_pkg::ADDR_CUT_PORTS_1_2)   ? cut12_r :
		(ptr_r == pcm_pkg::ADDR_CUT_PORTS_3_4)   ? cut34_r :
		(ptr_r == pcm_pkg::ADDR_DIE_TEMP)        ? temp_r :
		(ptr_r == pcm_pkg::ADDR_VIN_LO)          ? vin_r[7:0] :
		(ptr_r == pcm_pkg::ADDR_VIN_HI)          ? {2'b00, hi_hold_r} :
		(ptr_r == pcm_pkg::ADDR_CUR1_LO)         ? cur1_r[7:0] :
		(ptr_r == pcm_pkg::ADDR_CUR1_HI)         ? {2'b00, hi_hold_r} :
		pcm_pkg::UNMAPPED_READ;

	////////////////////////////////////////////////////////////////////////////////
	// interrupt deferral

	logic [pcm_pkg::DEFER_W-1:0] defer_n_w;
	logic [pcm_pkg::CNT_W-1:0]   pre_cnt_r;
	logic [pcm_pkg::DEFER_W-1:0] step_cnt_r;
	logic [IRQ_W-1:0]            pending_r;
	logic                        tick_w;
	logic                        fire_w;
	logic                        bypass_w;

	assign defer_n_w = defer_r[pcm_pkg::DEFER_LSB +: pcm_pkg::DEFER_W];
	assign bypass_w  = (defer_n_w == '0);
	assign tick_w    = (pre_cnt_r == STEP_CYC - 1'b1);
	assign fire_w    = ~bypass_w & tick_w & (step_cnt_r == '0);

	// a write restarts the period so a new value takes effect from the write
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pre_cnt_r  <= '0;
			step_cnt_r <= '0;
		end else if (wr_defer_w || bypass_w) begin
			pre_cnt_r  <= '0;
			step_cnt_r <= shift_r[pcm_pkg::DEFER_LSB +: pcm_pkg::DEFER_W] - 1'b1;
		end else if (tick_w) begin
			pre_cnt_r  <= '0;
			step_cnt_r <= (step_cnt_r == '0) ? defer_n_w - 1'b1 : step_cnt_r - 1'b1;
		end else begin
			pre_cnt_r <= pre_cnt_r + 1'b1;
		end
	end

	// events landing on the forwarding cycle go out with it, none is dropped
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pending_r   <= '0;
			irq_event_o <= '0;
		end else if (bypass_w || fire_w) begin
			pending_r   <= '0;
			irq_event_o <= pending_r | noncrit_event_i;
		end else begin
			pending_r   <= pending_r | noncrit_event_i;
			irq_event_o <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// two-event classification and per-port timers

	logic [pcm_pkg::PORTS-1:0] pwon_arm_r;
	logic [pcm_pkg::PORTS-1:0] class_start_r;

	for (genvar p = 0; p < pcm_pkg::PORTS; p++) begin : g_port
		// codes 01 and 11 share bit 0 set; reserved 10 behaves as off
		assign second_class_event_enable_o[p] = class_r[p*pcm_pkg::CLASS_W];

		always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				pwon_arm_r[p]    <= 1'b0;
				class_start_r[p] <= 1'b0;
			end else begin
				pwon_arm_r[p]    <= (pwon_arm_r[p] & ~class4_result_i[p]) | power_on_pushbutton_i[p];
				class_start_r[p] <= class4_result_i[p] & second_class_event_enable_o[p] &
					(~semi_auto_mode_i | classification_enable_i[p] | pwon_arm_r[p]);
			end
		end

		pcm_port_timer #(
			.DIS_CYCLES (DIS_CYCLES),
			.CUT_CYCLES (CUT_CYCLES),
			.I_STEP_NA  (I_STEP_NA)
		) u_timer (
			.ref_clk_i    (ref_clk_i),
			.sys_rst_i    (sys_rst_i),
			.powered_i    (port_powered_i[p]),
			.current_i    (port_current_i[p]),
			.disc_code_i  (disc_r[p*pcm_pkg::DISC_W +: pcm_pkg::DISC_W]),
			.cut_code_i   ((p < 2) ? cut12_r[(p % 2)*pcm_pkg::CUT_NIBBLE +: pcm_pkg::CUT_W]
			                       : cut34_r[(p % 2)*pcm_pkg::CUT_NIBBLE +: pcm_pkg::CUT_W]),
			.disconnect_o (disconnect_o[p]),
			.cut_fault_o  (overcurrent_fault_o[p])
		);
	end

	assign second_class_start_o = class_start_r;

endmodule

// ==== tb/pcm_regs_monitor.sv ====
// port-level checker for the config and monitor register bank
`timescale 1ns/1ns
module pcm_regs_monitor #(
	parameter int IRQ_W = 8
) (
	// clock and reset
	input wire logic             ref_clk_i,
	input wire logic             sys_rst_i,
	// bus and events
	input wire logic             scl_i,
	input wire logic             sda_o,
	input wire logic             sda_oe_o,
	input wire logic [IRQ_W-1:0] irq_event_o,
	// ports and classification
	input wire logic [3:0][13:0] port_current_i,
	input wire logic [3:0]       port_powered_i,
	input wire logic [3:0]       disconnect_o,
	input wire logic [3:0]       overcurrent_fault_o,
	input wire logic             semi_auto_mode_i,
	input wire logic [3:0]       class4_result_i,
	input wire logic [3:0]       second_class_event_enable_o,
	input wire logic [3:0]       second_class_start_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////////////////////////////
	sequence s_class_req;
		class4_result_i[0] && second_class_event_enable_o[0] && !semi_auto_mode_i;
	endsequence
	// 819 is the largest disconnect threshold code, so any disconnect needs less
	sequence s_disc_cause;
		$past(port_powered_i[1], 1) && $past(port_current_i[1], 1) < 14'h333;
	endsequence
	////////////////////////////////////////////////////////////////
	a_sda_open_drain: assert property (sda_o == 1'b0)
		else $error("sda value not low");
	a_sda_bit_stable: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("sda moved while scl high");
	a_rst_quiet_out: assert property ($fell(sys_rst_i) |-> irq_event_o == '0 && disconnect_o == 4'h0)
		else $error("output active right after reset");
	a_disc_one_pulse: assert property ((|disconnect_o) |=> (disconnect_o & $past(disconnect_o)) == 4'h0)
		else $error("disconnect pulse too long");
	a_disc_has_cause: assert property (disconnect_o[1] |-> s_disc_cause)
		else $error("disconnect without low current");
	a_cut_one_pulse: assert property ((|overcurrent_fault_o) |=> !(|(overcurrent_fault_o & $past(overcurrent_fault_o))))
		else $error("cut fault pulse too long");
	a_cut_has_cause: assert property (overcurrent_fault_o[2] |-> $past(port_current_i[2], 1) > 14'h70A)
		else $error("cut fault below lowest threshold");
	a_class_fires: assert property (s_class_req |=> second_class_start_o[0])
		else $error("second class event missing");
	a_class_gated: assert property (second_class_start_o[0] |-> $past(class4_result_i[0]) && $past(second_class_event_enable_o[0]))
		else $error("second class event without cause");
endmodule
bind pcm_regs pcm_regs_monitor #(.IRQ_W(IRQ_W)) u_mon (
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.irq_event_o(irq_event_o), .port_current_i(port_current_i), .port_powered_i(port_powered_i),
	.disconnect_o(disconnect_o), .overcurrent_fault_o(overcurrent_fault_o), .semi_auto_mode_i(semi_auto_mode_i),
	.class4_result_i(class4_result_i), .second_class_event_enable_o(second_class_event_enable_o),
	.second_class_start_o(second_class_start_o));

// ==== tb/pcm_i2c_host.sv ====
// i2c host model that reaches the register bank
`timescale 1ns/1ns
module pcm_i2c_host #(
	parameter logic [6:0] DEV = 7'h20
) (
	// clock
	input wire logic clk_i,
	// bus, scl stays high between frames
	input wire logic sda_i,
	output logic     scl_o,
	output logic     sda_oe_o
);
	logic ld;
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
		ld = 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// five clocks a quarter bit keeps each level well past the two-flop sync
	task automatic ph(input logic c, input logic d);
		repeat (5) @(posedge clk_i);
		scl_o <= c;
		sda_oe_o <= !d;
	endtask
	task automatic bitx(input logic d, output logic s);
		ph(1'b0, ld);
		ph(1'b0, d);
		ph(1'b1, d);
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		s = sda_i;
		ld = d;
	endtask
	// start is (1,0), stop is (0,1): the first level is set while scl is low, the second moves while scl is high
	task automatic edge2(input logic a, input logic b);
		ph(1'b0, ld);
		ph(1'b0, a);
		ph(1'b1, a);
		ph(1'b1, b);
		ld = b;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx, output logic ao);
		for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
		bitx(ai, ao);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
		logic [7:0] r;
		logic k0, k1, k2;
		edge2(1'b1, 1'b0);
		xfer({DEV, 1'b0}, 1'b1, r, k0);
		xfer(a, 1'b1, r, k1);
		xfer(d, 1'b1, r, k2);
		edge2(1'b0, 1'b1);
		nak = k0 | k1 | k2;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		logic [7:0] r;
		logic k;
		edge2(1'b1, 1'b0);
		xfer({DEV, 1'b0}, 1'b1, r, k);
		xfer(a, 1'b1, r, k);
		edge2(1'b1, 1'b0);
		xfer({DEV, 1'b1}, 1'b1, r, k);
		xfer(8'hFF, 1'b0, v[7:0], k);
		xfer(8'hFF, 1'b1, v[15:8], k);
		edge2(1'b0, 1'b1);
	endtask
endmodule

// ==== tb/pcm_regs_tb_top.sv ====
// self-checking testbench for the config and monitor register bank
`timescale 1ns/1ns
module pcm_regs_tb_top;
	logic             ref_clk_i = 1'b0;
	logic             sys_rst_i = 1'b1;
	logic             scl, h_oe, d_oe, mv = 1'b0, semi = 1'b0, nak;
	wire logic        sda_w;
	logic [7:0]       ev = 8'h00, temp = 8'h00, irq;
	logic [13:0]      vin = 14'h0000;
	logic [3:0][13:0] cur = 56'h0;
	logic [3:0]       pwr = 4'h0, classification_enable = 4'h0, pb = 4'h0, c4 = 4'h0, disc, cut, en, st;
	logic [15:0]      v;
	int               fail_count = 0, cmp_count = 0;
	// sda has a pull-up, so it is high unless someone pulls it low
	assign sda_w = !(h_oe | d_oe);
	always #10 ref_clk_i = ~ref_clk_i;
	pcm_i2c_host u_host (.clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(h_oe));
	// short counts keep the run brief, expectations derive from them
	pcm_regs #(.STEP_CYC(26'h00000A), .REFRESH_CYC(26'h000014), .DIS_CYCLES(26'h000005), .CUT_CYCLES(26'h000005)) u_dut (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe_o(d_oe),
		.noncrit_event_i(ev), .irq_event_o(irq), .meas_valid_i(mv), .temp_code_i(temp), .vin_code_i(vin),
		.port_current_i(cur), .port_powered_i(pwr), .disconnect_o(disc), .overcurrent_fault_o(cut),
		.semi_auto_mode_i(semi), .classification_enable_i(classification_enable), .power_on_pushbutton_i(pb),
		.class4_result_i(c4), .second_class_event_enable_o(en), .second_class_start_o(st));
	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wait_irq(output int n);
		n = 0;
		do begin
			@(negedge ref_clk_i);
			n++;
		end while (irq === 8'h00 && n < 40);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [7:0] a [7] = '{8'h27, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2E, 8'h30};
		foreach (a[i]) begin
			u_host.rd(a[i], v);
			check("reset value", v, 16'h0000);
		end
	endtask
	task automatic t_cfg;
		u_host.wr(8'h29, 8'hE4, nak);
		check("write ack", nak, 1'b0);
		u_host.rd(8'h29, v);
		check("disconnect fields", v[7:0], 8'hE4);
		u_host.wr(8'h2A, 8'hFF, nak);
		u_host.wr(8'h2B, 8'h45, nak);
		u_host.rd(8'h2A, v);
		check("cut fields", v, 16'h4577);
		u_host.wr(8'h27, 8'h0B, nak);
		u_host.rd(8'h27, v);
		check("deferral readback", v[7:0], 8'h0B);
	endtask
	task automatic t_defer;
		int n;
		u_host.wr(8'h27, 8'h00, nak);
		@(posedge ref_clk_i) ev <= 8'h81;
		@(posedge ref_clk_i) ev <= 8'h00;
		@(negedge ref_clk_i);
		check("pass through", irq, 8'h81);
		u_host.wr(8'h27, 8'h02, nak);
		@(posedge ref_clk_i) ev <= 8'h18;
		@(posedge ref_clk_i) ev <= 8'h00;
		wait_irq(n);
		check("deferred batch", irq, 8'h18);
		@(posedge ref_clk_i) ev <= 8'h24;
		@(posedge ref_clk_i) ev <= 8'h00;
		wait_irq(n);
		check("deferral period", n + 1, 16'h0014);
		check("next batch", irq, 8'h24);
	endtask
	task automatic t_meas;
		@(posedge ref_clk_i) begin
			temp <= 8'hA5;
			cur[0] <= 14'h12BC;
			vin <= 14'h3ABC;
			mv <= 1'b1;
		end
		@(posedge ref_clk_i) mv <= 1'b0;
		repeat (25) @(posedge ref_clk_i);
		u_host.wr(8'h30, 8'h00, nak);
		u_host.wr(8'h2C, 8'h00, nak);
		u_host.rd(8'h2C, v);
		check("temperature", v[7:0], 8'hA5);
		u_host.rd(8'h30, v);
		check("port1 current", v, 16'h12BC);
		u_host.rd(8'h2E, v);
		check("supply", v, 16'h3ABC);
		@(posedge ref_clk_i) vin <= 14'h0123;
		repeat (25) @(posedge ref_clk_i);
		u_host.rd(8'h2E, v);
		check("supply refresh", v, 16'h0123);
	endtask
	task automatic t_ports;
		logic [3:0] dacc = 4'h0, facc = 4'h0;
		u_host.wr(8'h29, 8'h0C, nak);
		u_host.wr(8'h2B, 8'h01, nak);
		@(posedge ref_clk_i) begin
			pwr <= 4'hF;
			cur <= {14'h07D0, 14'h07D0, 14'h01F4, 14'h0079};
		end
		repeat (30) begin
			@(negedge ref_clk_i);
			dacc |= disc;
			facc |= cut;
		end
		check("disconnect ports", dacc, 4'h3);
		check("cut ports", facc, 4'h4);
		@(posedge ref_clk_i) pwr <= 4'h0;
	endtask
	task automatic t_class;
		for (int c = 0; c < 4; c++) begin
			u_host.wr(8'h21, {4{c[1:0]}}, nak);
			@(posedge ref_clk_i) c4 <= 4'hF;
			@(posedge ref_clk_i) c4 <= 4'h0;
			@(negedge ref_clk_i);
			check("class enable", en, {4{c[0]}});
			check("class start", st, {4{c[0]}});
		end
		@(posedge ref_clk_i) begin
			semi <= 1'b1;
			classification_enable <= 4'h4;
			pb <= 4'h2;
		end
		@(posedge ref_clk_i) begin
			pb <= 4'h0;
			c4 <= 4'hF;
		end
		@(posedge ref_clk_i) c4 <= 4'h0;
		@(negedge ref_clk_i);
		check("semi auto start", st, 4'h6);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		t_reset();
		t_cfg();
		t_defer();
		t_meas();
		t_ports();
		t_class();
		results();
	end
	// the scenarios need about 22000 cycles, nearly three times that means a hang
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		fail_count++;
		results();
	end
endmodule
